// *** core/ddcm_regs.vh ***
`ifndef DDCM_REGS_VH
`define DDCM_REGS_VH
// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define DDCM_IDX_DECIM_CTRL 6'h25
`define DDCM_IDX_MIXER 6'h26
`define DDCM_IDX_ORDER_A 6'h27
`define DDCM_IDX_FREQ_A 6'h28
`define DDCM_IDX_FREQ_B 6'h29
`define DDCM_IDX_PHASE_A 6'h30
`define DDCM_IDX_PHASE_B 6'h31
// ****************************************
// Field positions
// ****************************************
`define DDCM_REAL_OUT_BIT 3
`define DDCM_GAIN_A_HI 7
`define DDCM_GAIN_A_LO 6
`define DDCM_RESTART_A_BIT 5
`define DDCM_QMIX_A_BIT 4
`define DDCM_GAIN_B_HI 3
`define DDCM_GAIN_B_LO 2
`define DDCM_RESTART_B_BIT 1
`define DDCM_QMIX_B_BIT 0
`define DDCM_SWAP_A_BIT 4
`define DDCM_QDEL_A_BIT 3
`define DDCM_QINV_A_BIT 2
// ****************************************
// Gain codes and reset values
// ****************************************
`define DDCM_GAIN_NONE 2'h0
`define DDCM_GAIN_3DB 2'h1
`define DDCM_GAIN_6DB 2'h2
`define DDCM_RST_MIXER 8'h00
`define DDCM_RST_ORDER_A 8'h00
`define DDCM_RST_DECIM_CTRL 8'h00
`define DDCM_RST_FREQ 32'h00000000
`endif

// *** core/ddcm_mixer_order.v ***
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "ddcm_regs.vh"
module ddcm_mixer_order #(
    parameter SAMPLE_W = 16,
    parameter OUT_W = 18
) (
    input wire clock,
    input wire srst,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire sample_valid,
    input wire [SAMPLE_W-1:0] chan_a_sample,
    input wire [SAMPLE_W-1:0] chan_b_sample,
    output reg out_valid_q,
    output reg [OUT_W-1:0] chan_a_first_q,
    output reg [OUT_W-1:0] chan_a_second_q,
    output reg [OUT_W-1:0] chan_b_i_q,
    output reg [OUT_W-1:0] chan_b_q_q
);
    // ****************************************
    // Helpers
    // ****************************************
    // Coarse quadrant rotation keeps the mixer multiplier free
    function [SAMPLE_W:0] rot_i;
        input [SAMPLE_W-1:0] x;
        input [1:0] k;
        reg [SAMPLE_W:0] xe;
        begin
            xe = {x[SAMPLE_W-1], x};
            case (k)
                2'h0: rot_i = xe;
                2'h2: rot_i = -xe;
                default: rot_i = {(SAMPLE_W+1){1'b0}};
            endcase
        end
    endfunction

    function [SAMPLE_W:0] rot_q;
        input [SAMPLE_W-1:0] x;
        input [1:0] k;
        reg [SAMPLE_W:0] xe;
        begin
            xe = {x[SAMPLE_W-1], x};
            case (k)
                2'h1: rot_q = -xe;
                2'h3: rot_q = xe;
                default: rot_q = {(SAMPLE_W+1){1'b0}};
            endcase
        end
    endfunction

    // 3 dB approximated as 1.40625 by shifts and adds
    function [OUT_W-1:0] apply_gain;
        input [SAMPLE_W:0] v;
        input [1:0] g;
        // Signed, so the right shifts keep the sign of negative samples
        reg signed [OUT_W-1:0] ve;
        begin
            ve = {{(OUT_W-SAMPLE_W-1){v[SAMPLE_W]}}, v};
            case (g)
                `DDCM_GAIN_3DB: apply_gain = ve + (ve >>> 2) + (ve >>> 3) + (ve >>> 5);
                `DDCM_GAIN_6DB: apply_gain = ve <<< 1;
                default: apply_gain = ve;
            endcase
        end
    endfunction

    // ****************************************
    // Register file
    // ****************************************
    reg [7:0] mixer_q;
    reg [7:0] order_a_q;
    reg real_out_q;
    reg [31:0] freq_a_q;
    reg [31:0] freq_b_q;
    wire [5:0] idx;
    wire acc_go;
    wire wr_go;
    reg [31:0] rd_d;
    wire [31:0] phase_a;
    wire [31:0] phase_b;
    // Next values of the stored fields
    reg [7:0] mixer_d;
    reg [7:0] order_a_d;
    reg real_out_d;
    wire [31:0] freq_a_d;
    wire [31:0] freq_b_d;
    wire hit_mixer;
    wire hit_order_a;
    wire hit_decim;
    wire [3:0] lane_a_we;
    wire [3:0] lane_b_we;
    reg wait_d;
    reg [31:0] rdata_d;

    assign idx = avs_address[7:2];
    assign acc_go = (avs_read | avs_write) & avs_waitrequest;
    assign wr_go = avs_write & ~avs_waitrequest;
    // Byte lane 0 carries every 8-bit register
    assign hit_mixer = wr_go & avs_byteenable[0] & (idx == `DDCM_IDX_MIXER);
    assign hit_order_a = wr_go & avs_byteenable[0] & (idx == `DDCM_IDX_ORDER_A);
    assign hit_decim = wr_go & avs_byteenable[0] & (idx == `DDCM_IDX_DECIM_CTRL);
    // Frequency lanes follow the byte enables
    assign lane_a_we = {4{wr_go & (idx == `DDCM_IDX_FREQ_A)}} & avs_byteenable;
    assign lane_b_we = {4{wr_go & (idx == `DDCM_IDX_FREQ_B)}} & avs_byteenable;

    // Reads have no side effects, so a repeated read is harmless
    always @* begin
        rd_d = 32'h00000000;
        if (idx == `DDCM_IDX_DECIM_CTRL) begin
            rd_d[`DDCM_REAL_OUT_BIT] = real_out_q;
        end else if (idx == `DDCM_IDX_MIXER) begin
            rd_d[7:0] = mixer_q;
        end else if (idx == `DDCM_IDX_ORDER_A) begin
            rd_d[7:0] = order_a_q;
        end else if (idx == `DDCM_IDX_FREQ_A) begin
            rd_d = freq_a_q;
        end else if (idx == `DDCM_IDX_FREQ_B) begin
            rd_d = freq_b_q;
        end else if (idx == `DDCM_IDX_PHASE_A) begin
            rd_d = phase_a;
        end else if (idx == `DDCM_IDX_PHASE_B) begin
            rd_d = phase_b;
        end
    end

    // ****************************************
    // Bus answer
    // ****************************************
    // One wait cycle, then the answer stands for one cycle
    // Each access costs two cycles; simple decode traded for bus rate
    always @* begin
        wait_d = avs_waitrequest;
        // Read data keeps its last value between answers
        rdata_d = avs_readdata;
        if (!avs_waitrequest) begin
            wait_d = 1'b1;
        end else if (acc_go) begin
            wait_d = 1'b0;
            rdata_d = avs_read ? rd_d : 32'h00000000;
        end
    end

    always @(posedge clock) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else begin
            avs_waitrequest <= wait_d;
            avs_readdata <= rdata_d;
        end
    end

    // ****************************************
    // Register storage
    // ****************************************
    always @* begin
        mixer_d = mixer_q;
        order_a_d = order_a_q;
        real_out_d = real_out_q;
        if (hit_mixer) begin
            // Restart bits are plain storage, never cleared by hardware
            mixer_d = avs_writedata[7:0];
        end
        if (hit_order_a) begin
            // Undefined bits are not stored, so they always read 0
            order_a_d = 8'h00;
            order_a_d[`DDCM_SWAP_A_BIT] = avs_writedata[`DDCM_SWAP_A_BIT];
            order_a_d[`DDCM_QDEL_A_BIT] = avs_writedata[`DDCM_QDEL_A_BIT];
            order_a_d[`DDCM_QINV_A_BIT] = avs_writedata[`DDCM_QINV_A_BIT];
        end
        if (hit_decim) begin
            real_out_d = avs_writedata[`DDCM_REAL_OUT_BIT];
        end
    end

    // Real mode holds both words at zero, overriding writes
    localparam N_LANE = 4;
    genvar ln;
    generate
        for (ln = 0; ln < N_LANE; ln = ln + 1) begin : g_lane
            assign freq_a_d[ln*8 +: 8] = real_out_q ? 8'h00 :
                (lane_a_we[ln] ? avs_writedata[ln*8 +: 8] : freq_a_q[ln*8 +: 8]);
            assign freq_b_d[ln*8 +: 8] = real_out_q ? 8'h00 :
                (lane_b_we[ln] ? avs_writedata[ln*8 +: 8] : freq_b_q[ln*8 +: 8]);
        end
    endgenerate

    always @(posedge clock) begin
        if (srst) begin
            mixer_q <= `DDCM_RST_MIXER;
            order_a_q <= `DDCM_RST_ORDER_A;
            real_out_q <= 1'b0;
            freq_a_q <= `DDCM_RST_FREQ;
            freq_b_q <= `DDCM_RST_FREQ;
        end else begin
            mixer_q <= mixer_d;
            order_a_q <= order_a_d;
            real_out_q <= real_out_d;
            freq_a_q <= freq_a_d;
            freq_b_q <= freq_b_d;
        end
    end

    // ****************************************
    // Per-channel oscillator and mixer
    // ****************************************
    wire [1:0] restart_bit;
    wire [1:0] qmix_en;
    wire [1:0] qinv_en;
    wire [3:0] gain_sel;
    wire [63:0] freq_all;
    wire [2*SAMPLE_W-1:0] samp_all;
    wire [2*OUT_W-1:0] mix_i_all;
    wire [2*OUT_W-1:0] mix_q_all;
    wire [63:0] phase_all;

    assign restart_bit = {mixer_q[`DDCM_RESTART_B_BIT], mixer_q[`DDCM_RESTART_A_BIT]};
    assign qmix_en = {mixer_q[`DDCM_QMIX_B_BIT], mixer_q[`DDCM_QMIX_A_BIT]};
    // Channel B invert lives in a register this block does not hold
    assign qinv_en = {1'b0, order_a_q[`DDCM_QINV_A_BIT]};
    assign gain_sel = {mixer_q[`DDCM_GAIN_B_HI:`DDCM_GAIN_B_LO], mixer_q[`DDCM_GAIN_A_HI:`DDCM_GAIN_A_LO]};
    assign freq_all = {freq_b_q, freq_a_q};
    assign samp_all = {chan_b_sample, chan_a_sample};
    // Phase readback lets software see that a restart took effect
    assign phase_a = phase_all[31:0];
    assign phase_b = phase_all[63:32];

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            reg restart_seen_q;
            reg [31:0] step_q;
            reg [31:0] phase_q;
            reg [1:0] quarter_q;
            wire [1:0] quarter_k;
            wire [1:0] rot_k;
            wire [SAMPLE_W-1:0] x;
            wire restart_edge;

            assign x = samp_all[ch*SAMPLE_W +: SAMPLE_W];
            // Edge seen one clock after the write lands
            assign restart_edge = restart_seen_q ^ restart_bit[ch];
            // Inverted phase runs the quarter-rate sequence backwards
            assign quarter_k = qinv_en[ch] ? (2'h0 - quarter_q) : quarter_q;
            assign rot_k = phase_q[31:30] + (qmix_en[ch] ? quarter_k : 2'h0);
            assign phase_all[ch*32 +: 32] = phase_q;
            // Real mode bypasses mixing on both channels
            assign mix_i_all[ch*OUT_W +: OUT_W] = real_out_q ?
                apply_gain({x[SAMPLE_W-1], x}, gain_sel[ch*2 +: 2]) :
                apply_gain(rot_i(x, rot_k), gain_sel[ch*2 +: 2]);
            assign mix_q_all[ch*OUT_W +: OUT_W] = real_out_q ? {OUT_W{1'b0}} :
                apply_gain(rot_q(x, rot_k), gain_sel[ch*2 +: 2]);

            always @(posedge clock) begin
                if (srst) begin
                    restart_seen_q <= 1'b0;
                    step_q <= `DDCM_RST_FREQ;
                    phase_q <= `DDCM_RST_FREQ;
                    quarter_q <= 2'h0;
                end else begin
                    restart_seen_q <= restart_bit[ch];
                    // Restart wins over a sample in the same cycle
                    if (restart_edge) begin
                        // Any edge of the stored bit restarts the oscillator
                        step_q <= real_out_q ? `DDCM_RST_FREQ : freq_all[ch*32 +: 32];
                        phase_q <= `DDCM_RST_FREQ;
                        quarter_q <= 2'h0;
                    end else if (sample_valid) begin
                        phase_q <= real_out_q ? `DDCM_RST_FREQ : phase_q + step_q;
                        // Counts samples, not clocks, so it follows any sample rate
                        quarter_q <= quarter_q + 2'h1;
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // Output ordering
    // ****************************************
    reg [OUT_W-1:0] prev_a_i_q;
    wire [OUT_W-1:0] a_i_pick;
    wire [OUT_W-1:0] a_q_now;
    reg [OUT_W-1:0] a_first_d;
    reg [OUT_W-1:0] a_second_d;

    assign a_q_now = mix_q_all[OUT_W-1:0];
    // Delay holds I back one sample so it meets the next Q
    assign a_i_pick = order_a_q[`DDCM_QDEL_A_BIT] ? prev_a_i_q : mix_i_all[OUT_W-1:0];

    // First pair after reset carries an I of zero when delay is on
    always @* begin
        if (order_a_q[`DDCM_SWAP_A_BIT]) begin
            a_first_d = a_q_now;
            a_second_d = a_i_pick;
        end else begin
            a_first_d = a_i_pick;
            a_second_d = a_q_now;
        end
    end

    always @(posedge clock) begin
        if (srst) begin
            prev_a_i_q <= {OUT_W{1'b0}};
            out_valid_q <= 1'b0;
            chan_a_first_q <= {OUT_W{1'b0}};
            chan_a_second_q <= {OUT_W{1'b0}};
            chan_b_i_q <= {OUT_W{1'b0}};
            chan_b_q_q <= {OUT_W{1'b0}};
        end else begin
            out_valid_q <= sample_valid;
            if (sample_valid) begin
                prev_a_i_q <= mix_i_all[OUT_W-1:0];
                chan_a_first_q <= a_first_d;
                chan_a_second_q <= a_second_d;
                // Channel B passes straight through; its order register is not held here
                chan_b_i_q <= mix_i_all[2*OUT_W-1:OUT_W];
                chan_b_q_q <= mix_q_all[2*OUT_W-1:OUT_W];
            end
        end
    end
endmodule // ddcm_mixer_order
`default_nettype wire

// *** verif/ddcm_mixer_order_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module ddcm_mixer_order_props #(
    parameter SAMPLE_W = 16,
    parameter OUT_W = 18
) (
    input wire clock,
    input wire srst,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire sample_valid,
    input wire out_valid_q,
    input wire [OUT_W-1:0] chan_a_first_q,
    input wire [OUT_W-1:0] chan_a_second_q,
    input wire [OUT_W-1:0] chan_b_i_q,
    input wire [OUT_W-1:0] chan_b_q_q
);
// ****************************************
// Bus and stream checks
// ****************************************
default clocking cb @(posedge clock); endclocking
default disable iff (srst);
sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
endsequence
sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
endsequence
chk_wait_one: assert property (s_taken |=> s_answer)
    else $error("waitrequest not low for exactly one cycle");
chk_idle_wait: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low without a request");
chk_unmapped_zero: assert property (avs_read && !avs_waitrequest
    && !(avs_address[7:2] inside {[6'h25:6'h29], 6'h30, 6'h31}) |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
chk_order_rsvd: assert property (avs_read && !avs_waitrequest && avs_address[7:2] == 6'h27
    |-> avs_readdata[31:5] == 27'h0 && avs_readdata[1:0] == 2'h0)
    else $error("order register reserved bits set");
chk_mixer_rsvd: assert property (avs_read && !avs_waitrequest && avs_address[7:2] == 6'h26
    |-> avs_readdata[31:8] == 24'h0)
    else $error("mixer register upper bits set");
chk_valid_next: assert property (sample_valid |=> out_valid_q)
    else $error("no output one cycle after sample");
chk_valid_only: assert property (!sample_valid |=> !out_valid_q)
    else $error("output valid without sample");
chk_data_hold: assert property (!sample_valid
    |=> $stable({chan_a_first_q, chan_a_second_q, chan_b_i_q, chan_b_q_q}))
    else $error("output words changed without sample");
endmodule // ddcm_mixer_order_props
bind ddcm_mixer_order ddcm_mixer_order_props #(.SAMPLE_W(SAMPLE_W), .OUT_W(OUT_W)) u_props (
    .clock(clock), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sample_valid(sample_valid), .out_valid_q(out_valid_q), .chan_a_first_q(chan_a_first_q),
    .chan_a_second_q(chan_a_second_q), .chan_b_i_q(chan_b_i_q), .chan_b_q_q(chan_b_q_q));
`default_nettype wire

// *** verif/ddcm_lvds_rx.sv ***
`timescale 1ns/10ps
`default_nettype none
module ddcm_lvds_rx #(
    parameter W = 18
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic word_valid,
    input wire logic [W-1:0] a_first,
    input wire logic [W-1:0] a_second,
    input wire logic [W-1:0] b_i,
    input wire logic [W-1:0] b_q,
    output logic [W-1:0] cap_a1,
    output logic [W-1:0] cap_a2,
    output logic [W-1:0] cap_bi,
    output logic [W-1:0] cap_bq
);
// Whole pair latched at once, so a torn pair is never seen
always_ff @(posedge clock) begin
    if (srst) begin
        {cap_a1, cap_a2, cap_bi, cap_bq} <= '0;
    end else if (word_valid) begin
        {cap_a1, cap_a2, cap_bi, cap_bq} <= {a_first, a_second, b_i, b_q};
    end
end
endmodule // ddcm_lvds_rx
`default_nettype wire

// *** verif/ddcm_mixer_order_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module ddcm_mixer_order_tb;
typedef struct packed {logic [7:0] dc, mix, ord; logic [1:0] ns; logic [17:0] a1, a2, bi, bq;} ddcm_row_t;
logic clock = 1'h0, srst = 1'h1, avs_read = 1'h0, avs_write = 1'h0, sample_valid = 1'h0, tog = 1'h0;
logic avs_waitrequest, out_valid_q;
logic [7:0] avs_address = 8'h00;
logic [3:0] avs_byteenable = 4'hF;
logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
logic [15:0] chan_a_sample = 16'h0100, chan_b_sample = 16'h0200;
logic [17:0] a1, a2, bi, bq, c_a1, c_a2, c_bi, c_bq;
ddcm_row_t rows [0:10];
int err_total = 0, tests_run = 0, cycles = 0;
initial forever #20 clock = ~clock;
ddcm_mixer_order dut (.clock(clock), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sample_valid(sample_valid),
    .chan_a_sample(chan_a_sample), .chan_b_sample(chan_b_sample), .out_valid_q(out_valid_q),
    .chan_a_first_q(a1), .chan_a_second_q(a2), .chan_b_i_q(bi), .chan_b_q_q(bq));
ddcm_lvds_rx rx (.clock(clock), .srst(srst), .word_valid(out_valid_q), .a_first(a1), .a_second(a2),
    .b_i(bi), .b_q(bq), .cap_a1(c_a1), .cap_a2(c_a2), .cap_bi(c_bi), .cap_bq(c_bq));
// ****************************************
// Tasks
// ****************************************
task automatic bus(input logic we, input logic [5:0] idx, input logic [31:0] d);
    @(posedge clock);
    avs_write <= we;
    avs_read <= !we;
    avs_address <= {idx, 2'h0};
    avs_writedata <= d;
    do @(posedge clock); while (avs_waitrequest !== 1'h0);
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
endtask
task automatic samp(input int n);
    repeat (n) begin
        @(posedge clock);
        sample_valid <= 1'h1;
        @(posedge clock);
        sample_valid <= 1'h0;
    end
    repeat (2) @(posedge clock);
endtask
task automatic cmp_w(input logic [17:0] got, input logic [17:0] exp);
    tests_run++;
    if (got !== exp) begin
        err_total++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task automatic cmp_r(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
        err_total++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task automatic give_verdict;
    $display("compares=%0d mismatches=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
endtask
// Hang guard, well above the few hundred cycles the run needs
always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
        err_total++;
        give_verdict;
    end
end
// ****************************************
// Sequence
// ****************************************
initial begin
    rows[0] = '{8'h00, 8'h00, 8'h00, 2'h1, 18'h00100, 18'h00000, 18'h00200, 18'h00000};
    rows[1] = '{8'h00, 8'h44, 8'h00, 2'h1, 18'h00168, 18'h00000, 18'h002D0, 18'h00000};
    rows[2] = '{8'h00, 8'h88, 8'h00, 2'h1, 18'h00200, 18'h00000, 18'h00400, 18'h00000};
    rows[3] = '{8'h00, 8'hCC, 8'h00, 2'h1, 18'h00100, 18'h00000, 18'h00200, 18'h00000};
    rows[4] = '{8'h00, 8'h00, 8'h10, 2'h1, 18'h00000, 18'h00100, 18'h00200, 18'h00000};
    rows[5] = '{8'h00, 8'h11, 8'h00, 2'h2, 18'h00000, 18'h3FF00, 18'h00000, 18'h3FE00};
    rows[6] = '{8'h00, 8'h11, 8'h04, 2'h2, 18'h00000, 18'h00100, 18'h00000, 18'h3FE00};
    rows[7] = '{8'h00, 8'h11, 8'h08, 2'h2, 18'h00100, 18'h3FF00, 18'h00000, 18'h3FE00};
    rows[8] = '{8'h00, 8'h11, 8'h18, 2'h2, 18'h3FF00, 18'h00100, 18'h00000, 18'h3FE00};
    rows[9] = '{8'h08, 8'h55, 8'h00, 2'h2, 18'h00168, 18'h00000, 18'h002D0, 18'h00000};
    rows[10] = '{8'h00, 8'h51, 8'h00, 2'h2, 18'h00000, 18'h3FE98, 18'h00000, 18'h3FE00};
    repeat (5) @(posedge clock);
    srst <= 1'h0;
    foreach (rows[i]) begin
        bus(1'h1, 6'h25, {24'h0, rows[i].dc});
        bus(1'h1, 6'h27, {24'h0, rows[i].ord});
        tog = !tog;
        bus(1'h1, 6'h26, {24'h0, rows[i].mix | (tog ? 8'h22 : 8'h00)});
        samp(rows[i].ns);
        cmp_w(c_a1, rows[i].a1);
        cmp_w(c_a2, rows[i].a2);
        cmp_w(c_bi, rows[i].bi);
        cmp_w(c_bq, rows[i].bq);
        $display("row %0d done", i);
    end
    // Restart bits must stay as written
    bus(1'h1, 6'h25, 32'h0);
    bus(1'h1, 6'h26, 32'h22);
    repeat (4) @(posedge clock);
    bus(1'h0, 6'h26, 32'h0);
    cmp_r(rd, 32'h22);
    bus(1'h1, 6'h27, 32'hFF);
    bus(1'h0, 6'h27, 32'h0);
    cmp_r(rd, 32'h1C);
    bus(1'h1, 6'h28, 32'h40000000);
    bus(1'h0, 6'h28, 32'h0);
    cmp_r(rd, 32'h40000000);
    bus(1'h1, 6'h26, 32'h0);
    samp(1);
    bus(1'h0, 6'h30, 32'h0);
    cmp_r(rd, 32'h40000000);
    bus(1'h1, 6'h26, 32'h22);
    bus(1'h0, 6'h30, 32'h0);
    cmp_r(rd, 32'h0);
    bus(1'h1, 6'h25, 32'h8);
    bus(1'h0, 6'h28, 32'h0);
    cmp_r(rd, 32'h0);
    bus(1'h1, 6'h28, 32'h12345678);
    bus(1'h0, 6'h28, 32'h0);
    cmp_r(rd, 32'h0);
    bus(1'h0, 6'h3F, 32'h0);
    cmp_r(rd, 32'h0);
    $display("register tests done");
    // Second reset in mid-run
    srst <= 1'h1;
    repeat (5) @(posedge clock);
    srst <= 1'h0;
    bus(1'h0, 6'h26, 32'h0);
    cmp_r(rd, 32'h0);
    bus(1'h0, 6'h27, 32'h0);
    cmp_r(rd, 32'h0);
    cmp_w(a1, 18'h00000);
    cmp_w(bq, 18'h00000);
    avs_byteenable <= 4'h3;
    bus(1'h1, 6'h28, 32'h12345678);
    avs_byteenable <= 4'hF;
    bus(1'h0, 6'h28, 32'h0);
    cmp_r(rd, 32'h00005678);
    $display("reset test done");
    give_verdict;
end
endmodule // ddcm_mixer_order_tb
`default_nettype wire
